// [verilog/cfb_pkg.sv]
// Constants, offsets and reset values of the chip configuration bank.
// Assumes a 13-bit serial instruction address and 8-bit registers.
// Operation
// - Bit order and soft reset sit mirrored in both nibbles of the port config register.
// - A soft reset returns every other register, and the output link, to defaults.
// - Once a soft reset has run, bits 2 and 5 of the port config register clear themselves.
// - The part identifier is an eight-bit read-only fixed code that ignores writes.
// - Speed code 00 selects 40 MSPS, 01 selects 65 MSPS and 10 selects 80 MSPS.
// - An update write reloads analog and converter defaults and applies the written speed code, keeping link, port and steering.
// - The update write acts only if the speed register was written since the last reset or accepted update write.
// - The low four bits of the second steering register enable channels E to H.
// - The first steering register enables channels A to D; the second also enables frame and data clock outputs.
// - Mode code 000 runs, 001 powers down by default, 011 resets the output link.
// - Bit 0 of the clock control register drives the duty cycle stabilizer, on by default.
// - Bit 7 of the lock monitor register reads the PLL lock state.
package cfb_pkg;
  // ===========================================================================
  // Register offsets
  localparam logic [12:0] CFB_OFS_PORT = 13'h0000;
  localparam logic [12:0] CFB_OFS_ID = 13'h0001;
  localparam logic [12:0] CFB_OFS_GRADE = 13'h0002;
  localparam logic [12:0] CFB_OFS_STEER_HI = 13'h0004;
  localparam logic [12:0] CFB_OFS_STEER_LO = 13'h0005;
  localparam logic [12:0] CFB_OFS_MODE = 13'h0008;
  localparam logic [12:0] CFB_OFS_CLK = 13'h0009;
  localparam logic [12:0] CFB_OFS_LOCK = 13'h000A;
  localparam logic [12:0] CFB_OFS_COMMIT = 13'h00FF;
  // ===========================================================================
  // Reset values and writable masks
  localparam logic [7:0] CFB_RST_PORT = 8'h18;
  localparam logic [7:0] CFB_MSK_PORT = 8'h66;
  localparam logic [7:0] CFB_SOFT_BITS = 8'h24;
  localparam logic [1:0] CFB_RST_SPEED = 2'h0;
  localparam logic [3:0] CFB_RST_STEER_HI = 4'hF;
  localparam logic [5:0] CFB_RST_STEER_LO = 6'h3F;
  localparam logic [2:0] CFB_RST_MODE = 3'h1;
  localparam logic CFB_RST_IMP = 1'b0;
  localparam logic CFB_RST_DCS = 1'b1;
  // ===========================================================================
  // Field positions
  localparam int CFB_BIT_LSB_HI = 6;
  localparam int CFB_BIT_LSB_LO = 1;
  localparam int CFB_BIT_SPEED = 4;
  localparam int CFB_BIT_IMP = 6;
  localparam int CFB_BIT_LOCK = 7;
  localparam int CFB_BIT_RNW = 15;
  // ===========================================================================
  // Serial frame layout, in bits
  localparam logic [4:0] CFB_INSTR_BITS = 5'd16;
  localparam logic [4:0] CFB_FRAME_BITS = 5'd24;
  // ===========================================================================
  // Codes
  typedef enum logic [1:0] {
    CFB_SPD_40 = 2'b00,
    CFB_SPD_65 = 2'b01,
    CFB_SPD_80 = 2'b10,
    CFB_SPD_80B = 2'b11
  } cfb_speed_t;
  localparam logic [2:0] CFB_MODE_RUN = 3'b000;
  localparam logic [2:0] CFB_MODE_OFF = 3'b001;
  localparam logic [2:0] CFB_MODE_LINK_RST = 3'b011;
endpackage : cfb_pkg

// [verilog/cfb_chip_config.sv]
// Chip configuration register bank behind a three-wire serial control port.
// Assumes the host frames each access with chip select low, 24 clocks.
`timescale 1ns/1ns
module cfb_chip_config #(
  parameter logic [7:0] PART_ID = 8'h5E // Arbitrary identifier value.
) (
  input wire logic sys_clk_i, // Core clock, 250 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic sclk_i, // Serial port clock from the host.
  input wire logic cs_n_i, // Serial frame select, active low.
  input wire logic sdio_i, // Serial data pin, input side.
  output logic sdio_o, // Serial data pin, output side.
  output logic sdio_oe_o, // Serial data pin drive enable.
  input wire logic pll_lock_i, // PLL lock level from the converter.
  output cfb_pkg::cfb_speed_t speed_mode_o, // Committed speed mode.
  output logic [7:0] chan_enable_o, // Steering enables, channels A to H.
  output logic fco_enable_o, // Steering enable, frame clock output.
  output logic dco_enable_o, // Steering enable, data clock output.
  output logic [2:0] op_mode_o, // Chip operating mode code.
  output logic lna_imp_low_o, // Low input impedance selected.
  output logic dcs_enable_o, // Duty cycle stabilizer on.
  output logic link_reset_o, // One-cycle reset of the output link.
  output logic analog_reload_o // One-cycle reload of analog defaults.
);
  import cfb_pkg::*;

  // ===========================================================================
  // Helpers
  // Reverses the bit order of a byte, used for the low-bit-first mode.
  function automatic logic [7:0] cfb_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : cfb_rev8

  // Selects the byte of the register image that an address reads.
  function automatic logic [7:0] cfb_pick(input logic [63:0] img,
                                          input logic [12:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      CFB_OFS_PORT: r = img[7:0];
      CFB_OFS_ID: r = img[15:8];
      CFB_OFS_GRADE: r = img[23:16];
      CFB_OFS_STEER_HI: r = img[31:24];
      CFB_OFS_STEER_LO: r = img[39:32];
      CFB_OFS_MODE: r = img[47:40];
      CFB_OFS_CLK: r = img[55:48];
      CFB_OFS_LOCK: r = img[63:56];
      default: r = 8'h00;
    endcase
    return r;
  endfunction : cfb_pick

  // ===========================================================================
  // Core-side register state
  logic [7:0] port_q;
  logic [1:0] speed_q;
  cfb_speed_t speed_act_q;
  logic grade_wr_q;
  logic [3:0] steer_hi_q;
  logic [5:0] steer_lo_q;
  logic [2:0] mode_q;
  logic imp_q;
  logic dcs_q;
  logic soft_pend_q;
  logic link_rst_q;
  logic reload_q;
  logic pll_s1_q;
  logic pll_s2_q;
  logic [63:0] img;

  // ===========================================================================
  // Link-side serial engine, clocked by the host's serial clock
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] instr_q;
  logic [12:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_done_q;
  logic [63:0] img_s1_q;
  logic [63:0] img_s2_q;
  logic [7:0] rd_sh_q;
  logic lsb_mode;
  logic [15:0] instr_in;
  logic [7:0] data_in;
  logic [7:0] rd_byte;

  // Bit order comes from the synchronized image; either nibble selects it.
  assign lsb_mode = img_s2_q[CFB_BIT_LSB_HI] | img_s2_q[CFB_BIT_LSB_LO];
  assign instr_in = lsb_mode
      ? {cfb_rev8({shift_q[6:0], sdio_i}), cfb_rev8(shift_q[14:7])}
      : {shift_q[14:0], sdio_i};
  assign data_in = lsb_mode ? cfb_rev8({shift_q[6:0], sdio_i})
                            : {shift_q[6:0], sdio_i};
  assign rd_byte = cfb_pick(img_s2_q, instr_q[12:0]); // Byte this read shows.

  // Registers settle long before the address phase ends, so a two-flop copy
  // of the whole image is flushed by the sixteen instruction clocks. The
  // clock stands still between frames, which is why no word is needed here.
  always_ff @(posedge sclk_i) begin
    img_s1_q <= img;
    img_s2_q <= img_s1_q;
  end

  // Frame counter and shifter, cleared by the frame's own select.
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_q <= 5'd0;
      shift_q <= 16'h0000;
      instr_q <= 16'h0000;
      wr_done_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[14:0], sdio_i};
      // The done level lasts until the select rises, so the host must keep
      // the select low for two core clocks after the last rising edge.
      if (bit_cnt_q == CFB_FRAME_BITS - 5'd1 && !instr_q[CFB_BIT_RNW]) begin
        wr_done_q <= 1'b1;
      end
      if (bit_cnt_q != CFB_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + 5'd1;
      end
      if (bit_cnt_q == CFB_INSTR_BITS - 5'd1) begin
        instr_q <= instr_in;
      end
    end
  end

  // A finished write frame publishes its word. The word stays put until the
  // next write frame, far beyond the core's sampling of the done level.
  always_ff @(posedge sclk_i) begin
    if (bit_cnt_q == CFB_FRAME_BITS - 5'd1 && !cs_n_i
        && !instr_q[CFB_BIT_RNW]) begin
      wr_addr_q <= instr_q[12:0];
      wr_data_q <= data_in;
    end
  end

  // Read data leaves on falling edges so the host samples it on rising ones.
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      sdio_oe_o <= 1'b0;
      sdio_o <= 1'b0;
      rd_sh_q <= 8'h00;
    end else if (bit_cnt_q == CFB_INSTR_BITS && instr_q[CFB_BIT_RNW]) begin
      sdio_oe_o <= 1'b1;
      rd_sh_q <= lsb_mode ? cfb_rev8(rd_byte) : rd_byte;
      sdio_o <= lsb_mode ? rd_byte[0] : rd_byte[7];
    end else if (bit_cnt_q == CFB_FRAME_BITS) begin
      sdio_oe_o <= 1'b0;
    end else if (sdio_oe_o) begin
      rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      sdio_o <= rd_sh_q[6];
    end
  end

  // ===========================================================================
  // Crossing of the write event into the core domain
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic wr_stb;
  logic [12:0] w_addr;
  logic [7:0] w_data;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      pll_s1_q <= 1'b0;
      pll_s2_q <= 1'b0;
    end else begin
      tgl_s1_q <= wr_done_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      pll_s1_q <= pll_lock_i;
      pll_s2_q <= pll_s1_q;
    end
  end
  assign wr_stb = tgl_s2_q & ~tgl_s3_q; // Rising edge of the done level.
  assign w_addr = wr_addr_q;
  assign w_data = wr_data_q;

  // ===========================================================================
  // Register file
  logic wr_port;
  logic wr_commit;
  logic commit_go;
  assign wr_port = wr_stb && w_addr == CFB_OFS_PORT;
  assign wr_commit = wr_stb && w_addr == CFB_OFS_COMMIT;
  assign commit_go = wr_commit && grade_wr_q;

  // Port config: only the mirrored bits store; the soft reset bits fall back
  // in the same cycle as the defaults are loaded.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      port_q <= CFB_RST_PORT;
      soft_pend_q <= 1'b0;
    end else if (wr_port) begin
      port_q <= (w_data & CFB_MSK_PORT) | CFB_RST_PORT;
      soft_pend_q <= |(w_data & CFB_SOFT_BITS);
    end else if (soft_pend_q) begin
      port_q <= port_q & ~CFB_SOFT_BITS;
      soft_pend_q <= 1'b0;
    end
  end

  // Speed field and its commit. The written code waits in a shadow and only
  // reaches the converter through an accepted update write.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_pend_q) begin
      speed_q <= CFB_RST_SPEED;
      speed_act_q <= CFB_SPD_40;
      grade_wr_q <= 1'b0;
    end else if (wr_stb && w_addr == CFB_OFS_GRADE) begin
      speed_q <= w_data[CFB_BIT_SPEED +: 2];
      grade_wr_q <= 1'b1;
    end else if (commit_go) begin
      speed_act_q <= (speed_q == CFB_SPD_80B) ? CFB_SPD_80
                     : cfb_speed_t'(speed_q);
      grade_wr_q <= 1'b0;
    end
  end

  // Steering enables; the update write leaves them alone.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_pend_q) begin
      steer_hi_q <= CFB_RST_STEER_HI;
      steer_lo_q <= CFB_RST_STEER_LO;
    end else if (wr_stb && w_addr == CFB_OFS_STEER_HI) begin
      steer_hi_q <= w_data[3:0];
    end else if (wr_stb && w_addr == CFB_OFS_STEER_LO) begin
      steer_lo_q <= w_data[5:0];
    end
  end

  // Global mode and clock control count as analog settings, so an accepted
  // update write restores them as well as a soft reset.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_pend_q || commit_go) begin
      mode_q <= CFB_RST_MODE;
      imp_q <= CFB_RST_IMP;
      dcs_q <= CFB_RST_DCS;
    end else if (wr_stb && w_addr == CFB_OFS_MODE) begin
      mode_q <= w_data[2:0];
      imp_q <= w_data[CFB_BIT_IMP];
    end else if (wr_stb && w_addr == CFB_OFS_CLK) begin
      dcs_q <= w_data[0];
    end
  end

  // Link reset on a soft reset or on mode code 011; reload on commit.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      link_rst_q <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      link_rst_q <= soft_pend_q || (wr_stb && w_addr == CFB_OFS_MODE
                    && w_data[2:0] == CFB_MODE_LINK_RST);
      reload_q <= commit_go;
    end
  end

  // Read image; reserved bits are constant zero and the identifier is fixed.
  assign img = {pll_s2_q, 7'h00,
                7'h00, dcs_q,
                1'b0, imp_q, 3'b000, mode_q,
                2'b00, steer_lo_q,
                4'h0, steer_hi_q,
                2'b00, speed_q, 4'h0,
                PART_ID,
                port_q};

  // ===========================================================================
  // Outputs, each from its own flop
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      speed_mode_o <= CFB_SPD_40;
      chan_enable_o <= {CFB_RST_STEER_HI, CFB_RST_STEER_LO[3:0]};
      fco_enable_o <= 1'b1;
      dco_enable_o <= 1'b1;
      op_mode_o <= CFB_RST_MODE;
      lna_imp_low_o <= CFB_RST_IMP;
      dcs_enable_o <= CFB_RST_DCS;
      link_reset_o <= 1'b0;
      analog_reload_o <= 1'b0;
    end else begin
      speed_mode_o <= speed_act_q;
      chan_enable_o <= {steer_hi_q, steer_lo_q[3:0]};
      fco_enable_o <= steer_lo_q[4];
      dco_enable_o <= steer_lo_q[5];
      op_mode_o <= mode_q;
      lna_imp_low_o <= imp_q;
      dcs_enable_o <= dcs_q;
      link_reset_o <= link_rst_q;
      analog_reload_o <= reload_q;
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_SOFT_CLEAR: assert property (soft_pend_q |=> port_q[5:2] == 4'h6)
    else $error("soft reset bits not cleared");
  AST_SOFT_DEFAULTS: assert property (soft_pend_q |=> steer_hi_q == 4'hF
      && mode_q == 3'h1 && dcs_q && !grade_wr_q)
    else $error("soft reset left a register off default");
  AST_ID_FIXED: assert property (img[15:8] == PART_ID)
    else $error("identifier changed");
  AST_COMMIT_GATED: assert property (wr_commit && !grade_wr_q
      |=> $stable(speed_act_q) && !reload_q)
    else $error("update acted without speed write");
  AST_COMMIT_APPLY: assert property (wr_commit && grade_wr_q
      && speed_q == 2'b01 |=> speed_act_q == CFB_SPD_65 ##1 analog_reload_o
      && speed_mode_o == CFB_SPD_65)
    else $error("commit did not apply speed");
  AST_SPEED_WAIT: assert property (wr_stb && w_addr == CFB_OFS_GRADE
      |=> $stable(speed_act_q))
    else $error("speed took effect before commit");
  AST_LINK_RST: assert property (wr_stb && w_addr == CFB_OFS_MODE
      && w_data[2:0] == 3'b011 |-> ##2 link_reset_o)
    else $error("link reset missing");
  AST_STEER_OUT: assert property (##1 chan_enable_o
      == $past({steer_hi_q, steer_lo_q[3:0]}))
    else $error("channel enables do not follow steering");
  AST_DCS: assert property (wr_stb && w_addr == CFB_OFS_CLK && !commit_go
      |-> ##2 dcs_enable_o == $past(w_data[0], 2))
    else $error("stabilizer output wrong");
  AST_LOCK: assert property (##2 img[63] == $past(pll_lock_i, 2))
    else $error("lock bit not shown");
  AST_RESV: assert property (img[23:16] == {2'b00, speed_q[1:0], 4'h0}
      && img[54:49] == 6'h00)
    else $error("reserved bits not zero");
endmodule : cfb_chip_config

// [sim/cfb_host_model.sv]
// Serial host model for the chip configuration bank's control port.
// Assumes the bench resolves the shared data line from the device's drive enable.
`timescale 1ns/1ns
module cfb_host_model (
  output logic sclk_o, // Serial clock, still between frames.
  output logic cs_n_o, // Frame select, active low.
  output logic sdio_o, // Host side of the data line.
  input wire logic line_i // Resolved data line level.
);
  // ==========================================================================
  // Frame engine
  // Idle levels before the first frame. A short select with the clock still
  // gives the device's link logic a rising select to clear on.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    sdio_o = 1'b0;
    #5 cs_n_o = 1'b1;
  end
  // One access per frame: 16 instruction bits, then one byte. When the host
  // lets go of the line it flips its level, so stale data never looks good.
  task automatic xfer(input logic rnw, input logic [12:0] a,
      input logic [7:0] wd, input logic lsb, output logic [7:0] rd);
    logic [15:0] ins;
    int i;
    ins = {rnw, 2'b00, a};
    rd = 8'h00;
    cs_n_o = 1'b0;
    for (i = 0; i < 24; i++) begin
      if (i < 16) sdio_o = lsb ? ins[i] : ins[15-i];
      else if (!rnw) sdio_o = lsb ? wd[i-16] : wd[23-i];
      else if (i == 16) sdio_o = ~sdio_o;
      #15 sclk_o = 1'b1;
      if (rnw && i >= 16) rd[lsb ? i-16 : 23-i] = line_i;
      #15 sclk_o = 1'b0;
    end
    #15 cs_n_o = 1'b1;
    sdio_o = ~sdio_o;
    // The core needs time to absorb a write before the next frame.
    #60;
  endtask : xfer
endmodule : cfb_host_model

// [sim/cfb_chip_config_tb.sv]
// Self-checking bench for the chip configuration bank.
// Assumes the host model task is reached by a hierarchical call.
`timescale 1ns/1ns
module cfb_chip_config_tb;
  import cfb_pkg::*;
  localparam logic [7:0] PID = 8'hC3; // Arbitrary identifier value.
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pll_lock = 1'b0;
  logic sclk, cs_n, host_sd, dut_sd, dut_oe, line;
  cfb_speed_t speed;
  logic [7:0] chan, rdv;
  logic [2:0] opm;
  logic frame_clock_output, data_clock_output, imp, duty_cycle_stabilizer, lrst, rld;
  int error_cnt = 0;
  int n_compared = 0;
  int c_lrst = 0;
  int c_rld = 0;
  int m_port, m_grade, m_spd, m_hi, m_lo, m_mode, m_clk, m_flag;
  int m_lrst = 0;
  int m_rld = 0;
  int k;
  int spd[4] = '{1, 3, 0, 2};
  logic [2:0] codes[3] = '{CFB_MODE_RUN, CFB_MODE_LINK_RST, CFB_MODE_OFF};
  logic [12:0] addrs[9] = '{CFB_OFS_PORT, CFB_OFS_ID, CFB_OFS_GRADE,
    CFB_OFS_STEER_HI, CFB_OFS_STEER_LO, CFB_OFS_MODE, CFB_OFS_CLK,
    CFB_OFS_LOCK, 13'h0003};
  // The device wins the line only while it enables its driver.
  assign line = dut_oe ? dut_sd : host_sd;
  initial forever #2 sys_clk = ~sys_clk;
  cfb_chip_config #(.PART_ID(PID)) dut_u (.sys_clk_i(sys_clk),
    .reset_n_i(reset_n), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(line),
    .sdio_o(dut_sd), .sdio_oe_o(dut_oe), .pll_lock_i(pll_lock),
    .speed_mode_o(speed), .chan_enable_o(chan), .fco_enable_o(frame_clock_output),
    .dco_enable_o(data_clock_output), .op_mode_o(opm), .lna_imp_low_o(imp),
    .dcs_enable_o(duty_cycle_stabilizer), .link_reset_o(lrst), .analog_reload_o(rld));
  cfb_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(host_sd),
    .line_i(line));
  // ==========================================================================
  // Reference model
  // Pulses are counted here so that a missed or doubled one shows up.
  always @(posedge sys_clk) begin
    if (lrst === 1'b1) c_lrst++;
    if (rld === 1'b1) c_rld++;
  end
  function automatic void m_defaults();
    m_grade = 0;
    m_spd = 0;
    m_hi = 8'h0F;
    m_lo = 8'h3F;
    m_mode = 8'h01;
    m_clk = 1;
    m_flag = 0;
  endfunction : m_defaults
  function automatic void m_wr(logic [12:0] a, logic [7:0] d);
    case (a)
      CFB_OFS_PORT: begin
        m_port = d & 8'h66;
        if ((d & 8'h24) != 0) begin
          m_defaults();
          m_port = m_port & 8'h42;
          m_lrst++;
        end
      end
      CFB_OFS_GRADE: begin
        m_grade = d & 8'h30;
        m_flag = 1;
      end
      CFB_OFS_STEER_HI: m_hi = d & 8'h0F;
      CFB_OFS_STEER_LO: m_lo = d & 8'h3F;
      CFB_OFS_MODE: begin
        m_mode = d & 8'h47;
        if (d[2:0] == 3'h3) m_lrst++;
      end
      CFB_OFS_CLK: m_clk = d & 8'h01;
      CFB_OFS_COMMIT: if (m_flag != 0) begin
        m_mode = 8'h01;
        m_clk = 1;
        m_flag = 0;
        m_spd = (m_grade >> 4) == 3 ? 2 : m_grade >> 4;
        m_rld++;
      end
      default: ;
    endcase
  endfunction : m_wr
  function automatic logic [7:0] m_rd(logic [12:0] a);
    case (a)
      CFB_OFS_PORT: return 8'(m_port | 8'h18);
      CFB_OFS_ID: return PID;
      CFB_OFS_GRADE: return 8'(m_grade);
      CFB_OFS_STEER_HI: return 8'(m_hi);
      CFB_OFS_STEER_LO: return 8'(m_lo);
      CFB_OFS_MODE: return 8'(m_mode);
      CFB_OFS_CLK: return 8'(m_clk);
      CFB_OFS_LOCK: return {pll_lock, 7'h00};
      default: return 8'h00;
    endcase
  endfunction : m_rd
  // ==========================================================================
  // Access and compare tasks
  task automatic chk_val(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_pins();
    logic [16:0] e, g;
    e = {m_spd[1:0], m_hi[3:0], m_lo[3:0], m_lo[4], m_lo[5],
      m_mode[2:0], m_mode[6], m_clk[0]};
    g = {speed, chan, frame_clock_output, data_clock_output, opm, imp, duty_cycle_stabilizer};
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL pins expected %h seen %h", e, g);
    end
  endtask : chk_pins
  // Bit order follows the port register as it stood before this frame.
  task automatic wr(logic [12:0] a, logic [7:0] d);
    logic [7:0] unused;
    host_u.xfer(1'b0, a, d, m_port[6] | m_port[1], unused);
    m_wr(a, d);
    repeat (10) @(posedge sys_clk);
  endtask : wr
  task automatic rd(logic [12:0] a, string nm);
    host_u.xfer(1'b1, a, 8'h00, m_port[6] | m_port[1], rdv);
    chk_val(nm, m_rd(a), rdv);
  endtask : rd
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(32'h5C17));
    m_port = 0;
    m_defaults();
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk_pins();
    foreach (addrs[i]) rd(addrs[i], "reset read");
    wr(CFB_OFS_ID, 8'($urandom));
    wr(CFB_OFS_LOCK, 8'hFF);
    rd(CFB_OFS_ID, "id");
    rd(CFB_OFS_LOCK, "lock ro");
    $display("test registers done");
    repeat (4) begin
      wr(CFB_OFS_STEER_HI, 8'($urandom));
      wr(CFB_OFS_STEER_LO, 8'($urandom));
      chk_pins();
      rd(CFB_OFS_STEER_HI, "steer hi");
      rd(CFB_OFS_STEER_LO, "steer lo");
    end
    foreach (codes[i]) begin
      wr(CFB_OFS_MODE, {1'b0, 1'($urandom), 3'h0, codes[i]});
      chk_pins();
      chk_val("link resets", 8'(m_lrst), 8'(c_lrst));
    end
    wr(CFB_OFS_CLK, 8'h00);
    chk_pins();
    wr(CFB_OFS_MODE, 8'h40);
    wr(CFB_OFS_COMMIT, 8'h01);
    chk_pins();
    chk_val("reloads", 8'(m_rld), 8'(c_rld));
    $display("test modes done");
    foreach (spd[i]) begin
      wr(CFB_OFS_GRADE, {2'b00, 2'(spd[i]), 4'h0});
      chk_pins();
      rd(CFB_OFS_GRADE, "grade");
      wr(CFB_OFS_MODE, 8'h43);
      wr(CFB_OFS_COMMIT, 8'($urandom));
      chk_pins();
      wr(CFB_OFS_CLK, 8'h00);
      wr(CFB_OFS_COMMIT, 8'h00);
      chk_pins();
      chk_val("reloads", 8'(m_rld), 8'(c_rld));
    end
    $display("test commit done");
    for (k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      pll_lock <= ~pll_lock;
      repeat (5) @(posedge sys_clk);
      rd(CFB_OFS_LOCK, "lock");
    end
    $display("test lock done");
    wr(CFB_OFS_PORT, 8'h42);
    rd(CFB_OFS_STEER_LO, "lsb read");
    wr(CFB_OFS_MODE, 8'h40);
    wr(CFB_OFS_PORT, 8'h66);
    chk_pins();
    chk_val("link resets", 8'(m_lrst), 8'(c_lrst));
    rd(CFB_OFS_PORT, "port");
    wr(CFB_OFS_PORT, 8'h00);
    wr(CFB_OFS_STEER_HI, 8'h05);
    wr(CFB_OFS_PORT, 8'h24);
    chk_pins();
    rd(CFB_OFS_PORT, "port");
    $display("test soft reset done");
    test_done();
  end
  // A hung frame or wait ends the run through the same closing task.
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule : cfb_chip_config_tb
